/* File: instr_issue_model.sv */
`timescale 1ns/1ps
module instr_issue_model
    import mul_low_pkg::*;
(
    input  wire op_kind_e    i_kind,
    input  wire logic [4:0]  i_tgt,
    input  wire logic [4:0]  i_src_a,
    input  wire logic [4:0]  i_src_b,
    input  wire logic        i_oe,
    input  wire logic        i_rec,
    input  wire logic [15:0] i_imm,
    output logic      [31:0] o_word
);
    always_comb begin
        case (i_kind)
            OP_IMM:  o_word = {OPC_MUL_IMM, i_tgt, i_src_a, i_imm};
            OP_DBL:  o_word = {OPC_EXTENDED, i_tgt, i_src_a, i_src_b, i_oe, XO_MUL_DBL, i_rec};
            OP_WORD: o_word = {OPC_EXTENDED, i_tgt, i_src_a, i_src_b, i_oe, XO_MUL_WORD, i_rec};
            // Opcode zero is not decoded, so the unit must stay silent
            default: o_word = {6'h00, i_tgt, i_src_a, i_src_b, i_oe, XO_MUL_WORD, i_rec};
        endcase
    end
endmodule : instr_issue_model

/* File: mul_low_core.sv */
`timescale 1ns/1ps
module mul_low_core
    import mul_low_pkg::*;
(
    input  wire logic [63:0] i_first,
    input  wire logic [63:0] i_second,
    input  wire logic [15:0] i_imm,
    output logic      [63:0] o_low_dbl,
    output logic             o_ovf_dbl,
    output logic      [31:0] o_low_word,
    output logic             o_ovf_word,
    output logic      [31:0] o_low_imm
);
    logic [127:0] prod_dbl;
    logic [63:0]  prod_word;
    logic [63:0]  prod_imm;

    // (RULE3) sign-extended operands; the low half does not depend on the extension
    assign prod_dbl  = {{64{i_first[63]}}, i_first} * {{64{i_second[63]}}, i_second};
    assign prod_word = {{32{i_first[31]}}, i_first[31:0]} * {{32{i_second[31]}}, i_second[31:0]};
    assign prod_imm  = {{32{i_first[31]}}, i_first[31:0]} * {{48{i_imm[15]}}, i_imm};

    assign o_low_dbl  = prod_dbl[63:0];
    assign o_ovf_dbl  = !((&prod_dbl[127:63]) || !(|prod_dbl[127:63]));
    assign o_low_word = prod_word[31:0];
    assign o_ovf_word = !((&prod_word[63:31]) || !(|prod_word[63:31]));
    assign o_low_imm  = prod_imm[31:0];

endmodule : mul_low_core

/* File: mul_low_pkg.sv */
package mul_low_pkg;

    // Instruction fields, numbered from the least significant bit of the word
    localparam int OPC_LSB = 26;
    localparam int TGT_LSB = 21;
    localparam int SRA_LSB = 16;
    localparam int SRB_LSB = 11;
    localparam int OE_POS  = 10;
    localparam int XO_LSB  = 1;
    localparam int REC_POS = 0;

    localparam logic [5:0] OPC_EXTENDED = 6'h1f;
    localparam logic [5:0] OPC_MUL_IMM  = 6'h07;
    localparam logic [8:0] XO_MUL_DBL   = 9'he9;
    localparam logic [8:0] XO_MUL_WORD  = 9'heb;

    localparam int          REG_W        = 64;
    localparam int          REG_COUNT    = 32;
    localparam logic [2:0]  EXC_RST      = 3'h0;
    localparam logic [3:0]  COND_RST     = 4'h0;
    localparam logic        IMPL_64_DEF  = 1'b1;

    typedef enum logic [3:0] {
        OP_NONE = 4'b0001,
        OP_DBL  = 4'b0010,
        OP_IMM  = 4'b0100,
        OP_WORD = 4'b1000
    } op_kind_e;

    // Signed comparison with zero: {negative, positive, zero}
    function automatic logic [2:0] cmp_zero(input logic sign_bit, input logic is_zero);
        cmp_zero = {sign_bit, !sign_bit && !is_zero, is_zero};
    endfunction : cmp_zero

endpackage : mul_low_pkg

/* File: multiply_low_unit.sv */
// Functional notes
// (RULE1) Opcode 31 with extended code 233 is the 64-bit multiply-low; OE and record select forms.
// (RULE2) 64-bit multiply-low writes low 64 bits of the 128-bit product.
// (RULE3) Low product is the same for signed or unsigned operands; overflow is signed.
// (RULE4) 64-bit multiply-low with OE set flags overflow and sticky summary on signed overflow.
// (RULE5) 64-bit multiply-low with record set updates condition field 0 from truncated result.
// (RULE6) 64-bit overflow bits come from the full 64-bit result, not the mode.
// (RULE7) A 32-bit implementation flags the 64-bit multiply-low as illegal.
// (RULE8) Opcode 07 is the immediate multiply: target, source, signed 16-bit immediate.
// (RULE9) Immediate sign-extended to 32 bits; low 32 product bits go to target.
// (RULE10) Immediate multiply leaves condition field 0 and exception register unchanged.
// (RULE11) Opcode 31 with extended code 235 is the 32-bit multiply-low; OE bit 21, record 31.
// (RULE12) 32-bit multiply-low writes the low 32 bits of the product.
// (RULE13) 32-bit multiply-low with OE set sets summary and overflow if product exceeds 32 bits.
// (RULE14) No form touches carry; forms with OE clear leave exception register alone.
// (RULE15) 32-bit multiply-low with record set updates condition field 0 from the result.
// (RULE16) Record: signed compare with zero, summary copied from exception register.
// (RULE17) Five-bit fields pick one of 32 registers; sources are read before the write.
`timescale 1ns/1ps
module multiply_low_unit
    import mul_low_pkg::*;
#(
    parameter logic IMPL_64 = IMPL_64_DEF
) (
    input  wire logic        i_clock,
    input  wire logic        i_sys_rst,
    input  wire logic        i_valid,
    input  wire logic [31:0] i_instr,
    input  wire logic        i_load_en,
    input  wire logic [4:0]  i_load_addr,
    input  wire logic [63:0] i_load_data,
    input  wire logic        i_exc_load,
    input  wire logic [2:0]  i_exc_data,
    input  wire logic [4:0]  i_peek_addr,
    output logic             o_done,
    output logic             o_illegal,
    output logic      [3:0]  o_cond_field,
    output logic             o_summary_flag,
    output logic             o_result_too_wide_flag,
    output logic             o_carry_out_bit,
    output logic      [63:0] o_peek_data
);
    logic [REG_W-1:0] general_register [REG_COUNT];
    logic [5:0]       opc;
    logic [8:0]       xo;
    logic [4:0]       target_register;
    logic [4:0]       first_source_reg;
    logic [4:0]       second_source_reg;
    logic             ovf_enable;
    logic             record_bit;
    op_kind_e         kind;
    logic [63:0]      src_a;
    logic [63:0]      src_b;
    logic [63:0]      low_dbl;
    logic [31:0]      low_word;
    logic [31:0]      low_imm;
    logic             ovf_dbl;
    logic             ovf_word;
    logic             exec_ok;
    logic             ovf_hit;
    logic             so_nxt;
    logic [63:0]      wr_value;
    logic [2:0]       flags_nxt;

    assign opc               = i_instr[OPC_LSB +: 6];
    assign xo                = i_instr[XO_LSB +: 9];
    // (RULE17) register specifiers
    assign target_register   = i_instr[TGT_LSB +: 5];
    assign first_source_reg  = i_instr[SRA_LSB +: 5];
    assign second_source_reg = i_instr[SRB_LSB +: 5];
    assign ovf_enable        = i_instr[OE_POS];
    assign record_bit        = i_instr[REC_POS];

    // (RULE1) (RULE8) (RULE11) opcode decode
    always_comb begin
        if (opc == OPC_MUL_IMM) begin
            kind = OP_IMM;
        end else if (opc == OPC_EXTENDED && xo == XO_MUL_DBL) begin
            kind = OP_DBL;
        end else if (opc == OPC_EXTENDED && xo == XO_MUL_WORD) begin
            kind = OP_WORD;
        end else begin
            kind = OP_NONE;
        end
    end

    // (RULE17) sources read combinationally, before the clocked write
    assign src_a = general_register[first_source_reg];
    assign src_b = general_register[second_source_reg];

    mul_low_core u_core (
        .i_first    (src_a),
        .i_second   (src_b),
        .i_imm      (i_instr[15:0]),
        .o_low_dbl  (low_dbl),
        .o_ovf_dbl  (ovf_dbl),
        .o_low_word (low_word),
        .o_ovf_word (ovf_word),
        .o_low_imm  (low_imm)
    );

    // (RULE7) 64-bit form only executes on a 64-bit implementation
    assign exec_ok = i_valid && (kind == OP_IMM || kind == OP_WORD || (kind == OP_DBL && IMPL_64));

    // (RULE6) overflow of the full 64-bit result for the 64-bit form; 32-bit overflow for the word form
    assign ovf_hit = (kind == OP_DBL) ? ovf_dbl : ovf_word;
    assign so_nxt  = o_summary_flag || (ovf_enable && ovf_hit);

    // Upper half of a word result is sign-extended so 64-bit readers see the same value
    always_comb begin
        case (kind)
            OP_DBL:  wr_value = low_dbl;
            OP_WORD: wr_value = {{32{low_word[31]}}, low_word};
            OP_IMM:  wr_value = {{32{low_imm[31]}}, low_imm};
            default: wr_value = 64'h0;
        endcase
    end

    // (RULE5) (RULE15) (RULE16) flags follow the written, possibly truncated, result
    always_comb begin
        if (kind == OP_DBL) begin
            flags_nxt = cmp_zero(low_dbl[63], low_dbl == 64'h0);
        end else begin
            flags_nxt = cmp_zero(low_word[31], low_word == 32'h0);
        end
    end

    // (RULE2) (RULE9) (RULE12) result write; an instruction wins over a load to the same register
    always_ff @(posedge i_clock) begin
        if (exec_ok) begin
            general_register[target_register] <= wr_value;
        end
        if (i_load_en && !(exec_ok && i_load_addr == target_register)) begin
            general_register[i_load_addr] <= i_load_data;
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_done    <= 1'b0;
            o_illegal <= 1'b0;
        end else begin
            o_done    <= exec_ok;
            o_illegal <= i_valid && kind == OP_DBL && !IMPL_64;
        end
    end

    // (RULE4) (RULE13) (RULE14) summary is sticky; carry only moves on an explicit load
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            {o_summary_flag, o_result_too_wide_flag, o_carry_out_bit} <= EXC_RST;
        end else if (exec_ok && kind != OP_IMM && ovf_enable) begin
            o_summary_flag         <= so_nxt;
            o_result_too_wide_flag <= ovf_hit;
        end else if (i_exc_load) begin
            {o_summary_flag, o_result_too_wide_flag, o_carry_out_bit} <= i_exc_data;
        end
    end

    // (RULE10) (RULE16) condition field; immediate form never records
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_cond_field <= COND_RST;
        end else if (exec_ok && kind != OP_IMM && record_bit) begin
            o_cond_field <= {flags_nxt, ovf_enable ? so_nxt : o_summary_flag};
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_peek_data <= 64'h0;
        end else begin
            o_peek_data <= general_register[i_peek_addr];
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    illegal_dbl_a: assert property (i_valid && kind == OP_DBL |=> o_illegal == !IMPL_64) // (RULE7)
        else $error("illegal flag wrong for double multiply");
    dbl_write_a: assert property (exec_ok && kind == OP_DBL ##1 !$past(i_load_en)
        |-> general_register[$past(target_register)] == $past(src_a * src_b)) // (RULE2)
        else $error("double low product not written");
    unsigned_same_a: assert property (exec_ok && kind == OP_DBL |-> low_dbl == 64'(src_a * src_b)) // (RULE3)
        else $error("low product differs from unsigned product");
    dbl_overflow_a: assert property (exec_ok && kind == OP_DBL && ovf_enable && ovf_dbl
        |=> o_result_too_wide_flag && o_summary_flag) // (RULE4)
        else $error("double overflow not flagged");
    record_dbl_a: assert property (exec_ok && kind == OP_DBL && record_bit
        |=> o_cond_field[3:1] == cmp_zero($past(low_dbl[63]), $past(low_dbl) == 64'h0)) // (RULE5)
        else $error("condition field wrong after double record");
    ovf_mode_a: assert property (exec_ok && kind == OP_DBL && ovf_enable && !ovf_dbl
        && $signed(low_dbl) != 0 |=> !o_result_too_wide_flag) // (RULE6)
        else $error("overflow set without 64-bit overflow");
    imm_write_a: assert property (exec_ok && kind == OP_IMM ##1 !$past(i_load_en)
        |-> general_register[$past(target_register)][31:0]
            == 32'($past(src_a[31:0]) * {{16{$past(i_instr[15])}}, $past(i_instr[15:0])})) // (RULE9)
        else $error("immediate product not written");
    imm_quiet_a: assert property (exec_ok && kind == OP_IMM && !i_exc_load
        |=> $stable(o_cond_field) && $stable({o_summary_flag, o_result_too_wide_flag})) // (RULE10)
        else $error("immediate multiply changed flags");
    word_overflow_a: assert property (exec_ok && kind == OP_WORD && ovf_enable && ovf_word
        |=> o_summary_flag && o_result_too_wide_flag) // (RULE13)
        else $error("word overflow not flagged");
    carry_kept_a: assert property (!i_exc_load |=> $stable(o_carry_out_bit)) // (RULE14)
        else $error("carry changed without load");
    word_oe_off_a: assert property (exec_ok && kind == OP_WORD && !ovf_enable && !i_exc_load
        |=> $stable({o_summary_flag, o_result_too_wide_flag})) // (RULE14)
        else $error("exception register changed with OE clear");
    so_copy_a: assert property (exec_ok && kind != OP_IMM && record_bit && !(i_exc_load && !ovf_enable)
        |=> o_cond_field[0] == o_summary_flag) // (RULE16)
        else $error("summary not copied to condition field");

    word_ovf_rec_c: cover property (exec_ok && kind == OP_WORD && ovf_enable && record_bit && ovf_word);
    dbl_ovf_c:      cover property (exec_ok && kind == OP_DBL && ovf_enable && ovf_dbl);
    imm_exec_c:     cover property (exec_ok && kind == OP_IMM ##1 exec_ok);
    same_reg_c:     cover property (exec_ok && target_register == first_source_reg);

endmodule : multiply_low_unit

/* File: multiply_low_unit_bench.sv */
`timescale 1ns/1ps
module multiply_low_unit_bench
    import mul_low_pkg::*;
;
    logic        i_clock     = 1'b0;
    logic        i_sys_rst   = 1'b1;
    logic        i_valid     = 1'b0;
    logic        i_load_en   = 1'b0;
    logic        i_exc_load  = 1'b0;
    logic [4:0]  i_load_addr = 5'h00;
    logic [4:0]  i_peek_addr = 5'h00;
    logic [63:0] i_load_data = 64'h0;
    logic [2:0]  i_exc_data  = 3'h0;
    op_kind_e    kind        = OP_NONE;
    logic [4:0]  tgt         = 5'h00;
    logic [4:0]  sa          = 5'h00;
    logic [4:0]  sb          = 5'h00;
    logic        oe          = 1'b0;
    logic        rec         = 1'b0;
    logic [15:0] imm         = 16'h0;
    logic [31:0] i_instr;
    logic        o_done, o_illegal, o_summary_flag, o_result_too_wide_flag, o_carry_out_bit;
    logic        done_32, illegal_32;
    logic [3:0]  o_cond_field;
    logic [63:0] o_peek_data;
    int          miscompares = 0;
    int          checks      = 0;
    int          cycles      = 0;

    always #25 i_clock = ~i_clock;

    instr_issue_model instr_issue_model_i (.i_kind(kind), .i_tgt(tgt), .i_src_a(sa), .i_src_b(sb),
        .i_oe(oe), .i_rec(rec), .i_imm(imm), .o_word(i_instr));
    multiply_low_unit multiply_low_unit_i (.i_clock, .i_sys_rst, .i_valid, .i_instr, .i_load_en,
        .i_load_addr, .i_load_data, .i_exc_load, .i_exc_data, .i_peek_addr, .o_done, .o_illegal,
        .o_cond_field, .o_summary_flag, .o_result_too_wide_flag, .o_carry_out_bit, .o_peek_data);
    // Narrow build sees the same traffic; only its done and illegal pulses are judged
    multiply_low_unit #(.IMPL_64(1'b0)) multiply_low_unit_i32 (.i_clock, .i_sys_rst, .i_valid,
        .i_instr, .i_load_en, .i_load_addr, .i_load_data, .i_exc_load, .i_exc_data, .i_peek_addr,
        .o_done(done_32), .o_illegal(illegal_32), .o_cond_field(), .o_summary_flag(),
        .o_result_too_wide_flag(), .o_carry_out_bit(), .o_peek_data());

    task automatic report_and_stop;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic load(input logic [4:0] a, input logic [63:0] d);
        i_load_en   = 1'b1;
        i_load_addr = a;
        i_load_data = d;
        @(negedge i_clock);
        i_load_en = 1'b0;
    endtask : load

    task automatic exc_load(input logic [2:0] d);
        i_exc_load = 1'b1;
        i_exc_data = d;
        @(negedge i_clock);
        i_exc_load = 1'b0;
    endtask : exc_load

    // Flags are {negative, positive, zero, field summary, summary, too wide, carry}
    task automatic exec(input op_kind_e k, input logic [4:0] t, a, b, input logic o, r,
                        input logic [15:0] im, input logic [63:0] er, input logic [6:0] ef);
        kind        = k;
        tgt         = t;
        sa          = a;
        sb          = b;
        oe          = o;
        rec         = r;
        imm         = im;
        i_valid     = 1'b1;
        i_peek_addr = t;
        @(negedge i_clock);
        i_valid = 1'b0;
        check("done", {63'h0, o_done}, {63'h0, k != OP_NONE});
        check("narrow", {62'h0, done_32, illegal_32}, {62'h0, k == OP_WORD || k == OP_IMM, k == OP_DBL});
        @(negedge i_clock);
        check("result", o_peek_data, er);
        check("flags", {57'h0, o_cond_field, o_summary_flag, o_result_too_wide_flag, o_carry_out_bit},
              {57'h0, ef});
    endtask : exec

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            report_and_stop();
        end
    end

    initial begin
        repeat (16) @(posedge i_clock);
        @(negedge i_clock);
        i_sys_rst = 1'b0;
        load(5'h04, 64'h3000);
        load(5'h0a, 64'h7000);
        exc_load(3'h1);
        exec(OP_WORD, 5'h06, 5'h04, 5'h0a, 1'b0, 1'b0, 16'h0, 64'h15000000, 7'h01);
        load(5'h04, 64'h4500);
        exec(OP_WORD, 5'h06, 5'h04, 5'h0a, 1'b0, 1'b1, 16'h0, 64'h1e300000, 7'h21);
        load(5'h0a, 64'h70000);
        exec(OP_WORD, 5'h06, 5'h04, 5'h0a, 1'b1, 1'b0, 16'h0, 64'hffffffffe3000000, 7'h27);
        load(5'h0a, 64'h7fffffff);
        exec(OP_WORD, 5'h06, 5'h04, 5'h0a, 1'b1, 1'b1, 16'h0, 64'hffffffffffffbb00, 7'h4f);
        exec(OP_IMM, 5'h07, 5'h04, 5'h00, 1'b0, 1'b0, 16'hfffe, 64'hffffffffffff7600, 7'h4f);
        exc_load(3'h0);
        load(5'h01, 64'hffffffffffffffff);
        load(5'h02, 64'hffffffffffffffff);
        exec(OP_DBL, 5'h03, 5'h01, 5'h02, 1'b1, 1'b1, 16'h0, 64'h1, 7'h20);
        load(5'h01, 64'h8000000000000000);
        load(5'h02, 64'h2);
        exec(OP_DBL, 5'h03, 5'h01, 5'h02, 1'b1, 1'b1, 16'h0, 64'h0, 7'h1e);
        load(5'h03, 64'h5);
        exec(OP_DBL, 5'h03, 5'h01, 5'h02, 1'b0, 1'b0, 16'h0, 64'h0, 7'h1e);
        load(5'h05, 64'h12345678fffffffd);
        exec(OP_WORD, 5'h05, 5'h05, 5'h05, 1'b1, 1'b0, 16'h0, 64'h9, 7'h1c);
        exec(OP_NONE, 5'h06, 5'h04, 5'h0a, 1'b1, 1'b1, 16'h0, 64'hffffffffffffbb00, 7'h1c);
        report_and_stop();
    end
endmodule : multiply_low_unit_bench
